// >>> src/tpb_pkg.sv
// constants and types for the tuner synthesizer and baseband control registers
package tpb_pkg;
	// register byte addresses inside the device
	localparam logic [7:0] OFS_SYNTH = 8'h06;
	localparam logic [7:0] OFS_BAND = 8'h07;
	localparam logic [7:0] OFS_FILTER = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h09;
	localparam logic [7:0] OFS_SHDN = 8'h0a;
	// seven-bit slave address with the select pin grounded
	localparam logic [6:0] SLAVE_ADDR = 7'h60;
	// bit positions
	localparam int POS_POSTDIV = 7;
	localparam int POS_PUMPSRC = 6;
	localparam int POS_MANPUMP = 5;
	localparam int BAND_HI = 7;
	localparam int BAND_LO = 3;
	localparam int POS_AUTO = 2;
	localparam int POS_LATCH = 1;
	localparam int POS_READ = 0;
	localparam int POS_SOFT_STANDBY = 7;
	localparam int POS_FACT = 5;
	localparam int GAIN_HI = 3;
	localparam int SHDN_HI = 6;
	// reset values
	localparam logic RST_POSTDIV = 1'b1;
	localparam logic RST_PUMPSRC = 1'b1;
	localparam logic RST_MANPUMP = 1'b0;
	localparam logic [4:0] RST_BAND = 5'h19;
	localparam logic RST_AUTO = 1'b0;
	localparam logic RST_LATCH = 1'b0;
	localparam logic RST_READ = 1'b0;
	localparam logic [7:0] RST_FILTER = 8'h4b;
	localparam logic RST_SOFT_STANDBY = 1'b0;
	localparam logic RST_FACT = 1'b0;
	localparam logic [3:0] RST_GAIN = 4'h0;
	localparam logic [6:0] RST_SHDN = 7'h00;
	// serial byte framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BIT_CNT_RST = 4'h0;
	localparam logic [1:0] PH_SLAVE = 2'h0;
	localparam logic [1:0] PH_REG = 2'h1;
	localparam logic [1:0] PH_DATA = 2'h2;

	// serial engine states, gray along idle-shift-ack
	typedef enum logic [1:0] {
		TPB_IDLE = 2'b00,
		TPB_SHIFT = 2'b01,
		TPB_ACK = 2'b11,
		TPB_SKIP = 2'b10
	} tpb_state_t;

	// stored register fields, don't-care bits have no storage
	typedef struct packed {
		logic postDiv;
		logic pumpSrc;
		logic manualPump;
		logic [4:0] oscBand;
		logic autoBand;
		logic adcLatch;
		logic adcRead;
		logic [7:0] filterCorner;
		logic softStandby;
		logic factoryPower;
		logic [3:0] gainCode;
		logic [6:0] sectionOff;
	} tpb_cfg_t;

	// control outputs toward the analog sections
	typedef struct packed {
		logic postDividerSelect;
		logic pumpCurrentHigh;
		logic [4:0] oscBandCode;
		logic autoBandEnable;
		logic tuneAdcLatchEn;
		logic tuneAdcReadEn;
		logic [7:0] filterCornerCode;
		logic softStandby;
		logic factoryPowerBit;
		logic [3:0] basebandGainCode;
		logic [6:0] sectionOff;
	} tpb_ctl_t;

	// whole module state
	typedef struct packed {
		tpb_state_t fsm;
		logic sclPrev;
		logic sdaPrev;
		logic [3:0] bitCnt;
		logic [7:0] shiftByte;
		logic [1:0] phase;
		logic [7:0] regPtr;
		logic sdaOe;
		logic sdaOut;
		tpb_cfg_t cfg;
		tpb_ctl_t ctl;
	} tpb_st_t;
endpackage : tpb_pkg

// >>> src/tpb_ctrl_regs.sv
// serial-written synthesizer, oscillator band, filter, gain and power-down control registers
`timescale 1ns/10ps

module tpb_ctrl_regs (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clkEn,
	// serial bus, data line open drain
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// address select strap and autoselect pump request
	input wire logic addrSelHigh,
	input wire logic autoPumpHigh,
	// controls toward analog sections
	output tpb_pkg::tpb_ctl_t ctl
);
	tpb_pkg::tpb_st_t st_q;
	tpb_pkg::tpb_st_t st_d;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic wrEn;

	// every assertion here belongs to core_clk and rests while reset is held
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// store one data byte into the addressed register, masking don't-care bits
	function automatic tpb_pkg::tpb_cfg_t applyWrite(input tpb_pkg::tpb_cfg_t c,
			input logic [7:0] ptr, input logic [7:0] b);
		tpb_pkg::tpb_cfg_t r;
		r = c;
		case (ptr)
			tpb_pkg::OFS_SYNTH: begin
				r.postDiv = b[tpb_pkg::POS_POSTDIV];
				r.pumpSrc = b[tpb_pkg::POS_PUMPSRC];
				r.manualPump = b[tpb_pkg::POS_MANPUMP];
			end
			tpb_pkg::OFS_BAND: begin
				r.oscBand = b[tpb_pkg::BAND_HI:tpb_pkg::BAND_LO];
				r.autoBand = b[tpb_pkg::POS_AUTO];
				r.adcLatch = b[tpb_pkg::POS_LATCH];
				r.adcRead = b[tpb_pkg::POS_READ];
			end
			tpb_pkg::OFS_FILTER: r.filterCorner = b;
			tpb_pkg::OFS_CTRL: begin
				r.softStandby = b[tpb_pkg::POS_SOFT_STANDBY];
				// stored as written, controller keeps it clear
				r.factoryPower = b[tpb_pkg::POS_FACT];
				r.gainCode = b[tpb_pkg::GAIN_HI:0];
			end
			tpb_pkg::OFS_SHDN: r.sectionOff = b[tpb_pkg::SHDN_HI:0];
			default: r = c;
		endcase
		return r;
	endfunction : applyWrite

	// bus line edges; inputs are already synchronous to core_clk
	assign sclRise = sclIn && !st_q.sclPrev;
	assign sclFall = !sclIn && st_q.sclPrev;
	assign startSeen = sclIn && st_q.sclPrev && st_q.sdaPrev && !sdaIn;
	assign stopSeen = sclIn && st_q.sclPrev && !st_q.sdaPrev && sdaIn;
	assign wrEn = clkEn && sclFall && st_q.fsm == tpb_pkg::TPB_SHIFT
		&& st_q.bitCnt == tpb_pkg::BITS_PER_BYTE && st_q.phase == tpb_pkg::PH_DATA;

	// next state: serial engine, register writes, derived controls
	always_comb begin
		st_d = st_q;
		st_d.sclPrev = sclIn;
		st_d.sdaPrev = sdaIn;
		st_d.sdaOut = 1'b0;
		if (startSeen) begin
			// repeated start also restarts framing
			st_d.fsm = tpb_pkg::TPB_SHIFT;
			st_d.bitCnt = tpb_pkg::BIT_CNT_RST;
			st_d.phase = tpb_pkg::PH_SLAVE;
			st_d.sdaOe = 1'b0;
		end else if (stopSeen) begin
			st_d.fsm = tpb_pkg::TPB_IDLE;
			st_d.sdaOe = 1'b0;
		end else begin
			case (st_q.fsm)
				tpb_pkg::TPB_SHIFT: begin
					if (sclRise && st_q.bitCnt != tpb_pkg::BITS_PER_BYTE) begin
						st_d.shiftByte = {st_q.shiftByte[6:0], sdaIn};
						st_d.bitCnt = st_q.bitCnt + 4'h1;
					end else if (sclFall && st_q.bitCnt == tpb_pkg::BITS_PER_BYTE) begin
						st_d.fsm = tpb_pkg::TPB_ACK;
						st_d.sdaOe = 1'b1;
						case (st_q.phase)
							tpb_pkg::PH_SLAVE: begin
								// address match; reads are not served here
								if (st_q.shiftByte[7:1] == (tpb_pkg::SLAVE_ADDR
										| {6'h00, addrSelHigh}) && !st_q.shiftByte[0]) begin
									st_d.phase = tpb_pkg::PH_REG;
								end else begin
									st_d.fsm = tpb_pkg::TPB_SKIP;
									st_d.sdaOe = 1'b0;
								end
							end
							tpb_pkg::PH_REG: begin
								st_d.regPtr = st_q.shiftByte;
								st_d.phase = tpb_pkg::PH_DATA;
							end
							default: begin
								st_d.cfg = applyWrite(st_q.cfg, st_q.regPtr, st_q.shiftByte);
								st_d.regPtr = st_q.regPtr + 8'h01;
							end
						endcase
					end
				end
				tpb_pkg::TPB_ACK: begin
					if (sclFall) begin
						st_d.sdaOe = 1'b0;
						st_d.fsm = tpb_pkg::TPB_SHIFT;
						st_d.bitCnt = tpb_pkg::BIT_CNT_RST;
					end
				end
				tpb_pkg::TPB_SKIP: st_d.sdaOe = 1'b0;
				tpb_pkg::TPB_IDLE: st_d.sdaOe = 1'b0;
				default: st_d.fsm = tpb_pkg::TPB_IDLE;
			endcase
		end
		// controls follow stored fields one cycle later
		st_d.ctl.postDividerSelect = st_q.cfg.postDiv;
		st_d.ctl.pumpCurrentHigh = st_q.cfg.pumpSrc ? autoPumpHigh : st_q.cfg.manualPump;
		st_d.ctl.oscBandCode = st_q.cfg.oscBand;
		st_d.ctl.autoBandEnable = st_q.cfg.autoBand;
		st_d.ctl.tuneAdcLatchEn = st_q.cfg.adcLatch && !st_q.cfg.autoBand;
		st_d.ctl.tuneAdcReadEn = st_q.cfg.adcRead && !st_q.cfg.autoBand;
		st_d.ctl.filterCornerCode = st_q.cfg.filterCorner;
		st_d.ctl.softStandby = st_q.cfg.softStandby;
		st_d.ctl.factoryPowerBit = st_q.cfg.factoryPower;
		st_d.ctl.basebandGainCode = st_q.cfg.gainCode;
		// standby forces every section off; reference path lives elsewhere
		st_d.ctl.sectionOff = st_q.cfg.sectionOff | {7{st_q.cfg.softStandby}};
	end

	// state register; clock enable low freezes everything
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_q <= '{fsm: tpb_pkg::TPB_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1,
				bitCnt: tpb_pkg::BIT_CNT_RST, shiftByte: 8'h00, phase: tpb_pkg::PH_SLAVE,
				regPtr: 8'h00, sdaOe: 1'b0, sdaOut: 1'b0,
				cfg: '{postDiv: tpb_pkg::RST_POSTDIV, pumpSrc: tpb_pkg::RST_PUMPSRC,
					manualPump: tpb_pkg::RST_MANPUMP, oscBand: tpb_pkg::RST_BAND,
					autoBand: tpb_pkg::RST_AUTO, adcLatch: tpb_pkg::RST_LATCH,
					adcRead: tpb_pkg::RST_READ, filterCorner: tpb_pkg::RST_FILTER,
					softStandby: tpb_pkg::RST_SOFT_STANDBY, factoryPower: tpb_pkg::RST_FACT,
					gainCode: tpb_pkg::RST_GAIN, sectionOff: tpb_pkg::RST_SHDN},
				ctl: '{postDividerSelect: tpb_pkg::RST_POSTDIV, pumpCurrentHigh: 1'b0,
					oscBandCode: tpb_pkg::RST_BAND, autoBandEnable: tpb_pkg::RST_AUTO,
					tuneAdcLatchEn: 1'b0, tuneAdcReadEn: 1'b0,
					filterCornerCode: tpb_pkg::RST_FILTER, softStandby: tpb_pkg::RST_SOFT_STANDBY,
					factoryPowerBit: tpb_pkg::RST_FACT, basebandGainCode: tpb_pkg::RST_GAIN,
					sectionOff: tpb_pkg::RST_SHDN}};
		end else if (clkEn) begin
			st_q <= st_d;
		end
	end

	assign ctl = st_q.ctl;
	assign sdaOe = st_q.sdaOe;
	assign sdaOut = st_q.sdaOut;

	// a write only lands on an enabled edge, so the stored bit is there one edge later
	property p_postdiv_write;
		wrEn && st_q.regPtr == tpb_pkg::OFS_SYNTH |=> st_q.cfg.postDiv
			== $past(st_q.shiftByte[tpb_pkg::POS_POSTDIV]);
	endproperty
	a_postdiv_write: assert property (p_postdiv_write) else $error("post divider not stored");

	property p_pump_select;
		clkEn |=> ctl.pumpCurrentHigh == ($past(st_q.cfg.pumpSrc) ? $past(autoPumpHigh)
			: $past(st_q.cfg.manualPump));
	endproperty
	a_pump_select: assert property (p_pump_select) else $error("pump current wrong source");

	property p_band_write;
		wrEn && st_q.regPtr == tpb_pkg::OFS_BAND |=> st_q.cfg.oscBand
			== $past(st_q.shiftByte[tpb_pkg::BAND_HI:tpb_pkg::BAND_LO]) ##1
			(!$past(clkEn) || ctl.oscBandCode == $past(st_q.cfg.oscBand));
	endproperty
	a_band_write: assert property (p_band_write) else $error("band code not applied");

	property p_adc_gate;
		clkEn && st_q.cfg.autoBand |=> !ctl.tuneAdcLatchEn && !ctl.tuneAdcReadEn;
	endproperty
	a_adc_gate: assert property (p_adc_gate) else $error("adc control active in autoselect");

	property p_filter_write;
		wrEn && st_q.regPtr == tpb_pkg::OFS_FILTER |=> st_q.cfg.filterCorner
			== $past(st_q.shiftByte) ##1 (!$past(clkEn)
			|| ctl.filterCornerCode == $past(st_q.cfg.filterCorner));
	endproperty
	a_filter_write: assert property (p_filter_write) else $error("corner code not applied");

	property p_standby;
		clkEn && st_q.cfg.softStandby |=> &ctl.sectionOff;
	endproperty
	a_standby: assert property (p_standby) else $error("standby left a section on");

	property p_gain_write;
		wrEn && st_q.regPtr == tpb_pkg::OFS_CTRL |=> st_q.cfg.gainCode
			== $past(st_q.shiftByte[tpb_pkg::GAIN_HI:0]);
	endproperty
	a_gain_write: assert property (p_gain_write) else $error("gain code not stored");

	property p_shdn_write;
		wrEn && st_q.regPtr == tpb_pkg::OFS_SHDN |=> st_q.cfg.sectionOff
			== $past(st_q.shiftByte[tpb_pkg::SHDN_HI:0]);
	endproperty
	a_shdn_write: assert property (p_shdn_write) else $error("power-down bits not stored");

	property p_autoinc;
		wrEn |=> st_q.regPtr == $past(st_q.regPtr) + 8'h01 && sdaOe;
	endproperty
	a_autoinc: assert property (p_autoinc) else $error("pointer or ack missing on data");

	property p_addr_nack;
		clkEn && sclFall && st_q.fsm == tpb_pkg::TPB_SHIFT && st_q.phase == tpb_pkg::PH_SLAVE
			&& st_q.bitCnt == tpb_pkg::BITS_PER_BYTE && !startSeen && !stopSeen
			&& st_q.shiftByte[7:1] != (tpb_pkg::SLAVE_ADDR | {6'h00, addrSelHigh})
			|=> !sdaOe && st_q.fsm == tpb_pkg::TPB_SKIP;
	endproperty
	a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");
endmodule : tpb_ctrl_regs

// >>> testbench/tpb_bus_master.sv
// two-wire bus master model that clocks the serial line and pulls data low
`timescale 1ns/10ps
module tpb_bus_master (
	// clock and resolved data wire
	input wire logic core_clk,
	input wire logic sdaWire,
	// lines driven toward the slave
	output logic scl,
	output logic sdaLow
);
	// four cycles per step keeps both clock phases above the two-edge minimum
	localparam int HALF = 4;

	// bus idles with both lines high, clock stands still between frames
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end

	// every change lands on a falling core clock edge
	task automatic tick();
		repeat (HALF) @(negedge core_clk);
	endtask : tick

	// start condition, also serves as repeated start
	task automatic start_cond();
		sdaLow = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sdaLow = 1'b1;
		tick();
		scl = 1'b0;
	endtask : start_cond

	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			tick();
			sdaLow = ~b[i];
			tick();
			scl = 1'b1;
			tick();
			scl = 1'b0;
		end
		tick();
		sdaLow = 1'b0;
		tick();
		scl = 1'b1;
		repeat (2) @(negedge core_clk);
		ack = ~sdaWire;
		repeat (2) @(negedge core_clk);
		scl = 1'b0;
	endtask : send_byte

	// stop condition, data rises while clock is high
	task automatic stop_cond();
		tick();
		sdaLow = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sdaLow = 1'b0;
		tick();
	endtask : stop_cond
endmodule : tpb_bus_master

// >>> testbench/tpb_ctrl_regs_tb_top.sv
// self-checking bench for the serial control register bank
`timescale 1ns/10ps
module tpb_ctrl_regs_tb_top;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic clkEn = 1'b1;
	logic addrSelHigh = 1'b0;
	logic autoPumpHigh = 1'b0;
	logic oeSeen = 1'b0;
	logic scl, sdaLow, sdaOut, sdaOe, sdaWire;
	tpb_pkg::tpb_ctl_t ctl;
	tpb_pkg::tpb_ctl_t expQ[$];
	logic [7:0] r [256];
	int error_cnt = 0;
	int samples_checked = 0;

	// open-drain data wire with pull-up
	assign sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));
	always #4 core_clk = ~core_clk;

	tpb_ctrl_regs u_dut (.core_clk(core_clk), .reset(reset), .clkEn(clkEn), .sclIn(scl),
		.sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelHigh(addrSelHigh),
		.autoPumpHigh(autoPumpHigh), .ctl(ctl));
	tpb_bus_master u_mst (.core_clk(core_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));

	function automatic tpb_pkg::tpb_ctl_t model();
		tpb_pkg::tpb_ctl_t c;
		c.postDividerSelect = r[6][7];
		c.pumpCurrentHigh = r[6][6] ? autoPumpHigh : r[6][5];
		c.oscBandCode = r[7][7:3];
		c.autoBandEnable = r[7][2];
		c.tuneAdcLatchEn = r[7][1] & ~r[7][2];
		c.tuneAdcReadEn = r[7][0] & ~r[7][2];
		c.filterCornerCode = r[8];
		c.softStandby = r[9][7];
		c.factoryPowerBit = r[9][5];
		c.basebandGainCode = r[9][3:0];
		c.sectionOff = r[10][6:0] | {7{r[9][7]}};
		return c;
	endfunction : model

	task automatic cmp_ctl(input tpb_pkg::tpb_ctl_t e, input tpb_pkg::tpb_ctl_t s);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD ctl expected %h seen %h", e, s);
		end
	endtask : cmp_ctl

	task automatic cmp_ack(input logic e, input logic s);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD ack expected %b seen %b", e, s);
		end
	endtask : cmp_ack

	// reset for five cycles, expectation back to power-on bytes
	task automatic do_reset();
		reset = 1'b1;
		r[6] = 8'hc0;
		r[7] = 8'hc8;
		r[8] = 8'h4b;
		r[9] = 8'h00;
		r[10] = 8'h00;
		repeat (5) @(negedge core_clk);
		reset = 1'b0;
		@(negedge core_clk);
		cmp_ctl(model(), ctl);
	endtask : do_reset

	// one write frame; every acked byte leaves a note for the watcher
	task automatic wr(input logic [7:0] sb, input logic [7:0] ra, input logic [7:0] d[$],
		input logic ok);
		logic a;
		logic [7:0] p;
		p = ra;
		u_mst.start_cond();
		u_mst.send_byte(sb, a);
		cmp_ack(ok, a);
		if (ok) expQ.push_back(model());
		u_mst.send_byte(ra, a);
		cmp_ack(ok, a);
		if (ok) expQ.push_back(model());
		foreach (d[i]) begin
			if (ok && p >= 8'h06 && p <= 8'h0a) r[p] = d[i];
			u_mst.send_byte(d[i], a);
			cmp_ack(ok, a);
			if (ok) expQ.push_back(model());
			p++;
		end
		u_mst.stop_cond();
	endtask : wr

	// the end of an ack means a byte was taken; compare with the oldest note
	always @(negedge core_clk) begin
		if (oeSeen && sdaOe === 1'b0) begin
			if (expQ.size() == 0) begin
				error_cnt++;
				$display("BAD note expected queued seen none");
			end else begin
				cmp_ctl(expQ.pop_front(), ctl);
			end
		end
		oeSeen = sdaOe;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	// hang guard, far beyond the expected run length
	initial begin
		repeat (40000) @(posedge core_clk);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		tpb_pkg::tpb_ctl_t held;
		logic [7:0] d[$];
		logic a;
		void'($urandom(32'h00f911de));
		do_reset();
		// enable low must freeze the outputs
		held = ctl;
		clkEn = 1'b0;
		autoPumpHigh = 1'b1;
		repeat (3) @(negedge core_clk);
		cmp_ctl(held, ctl);
		clkEn = 1'b1;
		@(negedge core_clk);
		cmp_ctl(model(), ctl);
		// random bursts over all five registers, don't-care bits random too
		for (int k = 0; k < 6; k++) begin
			autoPumpHigh = 1'($urandom());
			d = {8'($urandom()), 8'($urandom()), 8'($urandom()), 8'($urandom()) & 8'hdf,
				8'($urandom())};
			wr(8'hc0, 8'h06, d, 1'b1);
			autoPumpHigh = ~autoPumpHigh;
			repeat (2) @(negedge core_clk);
			cmp_ctl(model(), ctl);
		end
		wr(8'hc0, 8'h0a, {8'hff, 8'h5a}, 1'b1);
		wr(8'hc0, 8'h09, {8'h8f}, 1'b1);
		wr(8'hc0, 8'h07, {8'h07}, 1'b1);
		wr(8'hc0, 8'h07, {8'h03}, 1'b1);
		// repeated start in the data phase must restart framing and store nothing
		u_mst.start_cond();
		u_mst.send_byte(8'hc0, a);
		cmp_ack(1'b1, a);
		expQ.push_back(model());
		u_mst.send_byte(8'h08, a);
		cmp_ack(1'b1, a);
		expQ.push_back(model());
		wr(8'hc0, 8'h09, {8'h05}, 1'b1);
		wr(8'hc2, 8'h08, {8'h00}, 1'b0);
		wr(8'hc1, 8'h08, {8'h00}, 1'b0);
		addrSelHigh = 1'b1;
		wr(8'hc2, 8'h08, {8'h11}, 1'b1);
		wr(8'hc0, 8'h08, {8'h22}, 1'b0);
		addrSelHigh = 1'b0;
		for (int g = 0; g < 16; g++) begin
			wr(8'hc0, 8'h09, {8'(g)}, 1'b1);
		end
		// a note left over means an expected ack never ended
		if (expQ.size() != 0) begin
			error_cnt++;
			$display("BAD notes expected 0 seen %0d", expQ.size());
		end
		do_reset();
		tally_and_finish();
	end
endmodule : tpb_ctrl_regs_tb_top
